// ==== include/i2stx_pkg.sv ====
// Constants for the serial audio transmit channel: register offsets,
// configuration field layout, encodings and link timing.
// Assumes a 200 MHz system clock and a plain strobe register port.
package i2stx_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_TX_CFG   = 8'h00;
  localparam logic [7:0] REG_JOINT_CFG = 8'h04;
  localparam logic [7:0] REG_CTRL     = 8'h08;
  localparam logic [7:0] REG_JOINT_EN = 8'h0c;
  localparam logic [7:0] REG_DATA     = 8'h10;
  localparam logic [7:0] REG_LEVEL    = 8'h14;
  localparam logic [7:0] REG_LIMIT    = 8'h18;
  localparam logic [7:0] REG_STATUS   = 8'h1c;
  localparam logic [7:0] REG_RX_CFG   = 8'h20;

  // Configuration word layout
  localparam int CFG_W          = 13;
  localparam int CFG_FMT_LSB    = 0;
  localparam int CFG_INV_BIT    = 2;
  localparam int CFG_MODE_LSB   = 3;
  localparam int CFG_MASTER_BIT = 5;
  localparam int CFG_SSZ_LSB    = 6;
  localparam int CFG_WSZ_LSB    = 9;
  localparam int CFG_REPEAT_BIT = 12;
  localparam logic [12:0] CFG_RST = 13'h0000;

  // Control bits and joint enable command bits
  localparam int CTRL_TX_EN_BIT = 0;
  localparam int CTRL_RX_EN_BIT = 1;
  localparam int JOINT_ON_BIT   = 0;
  localparam int JOINT_OFF_BIT  = 1;
  localparam int STAT_REQ_BIT   = 0;
  localparam int STAT_FULL_BIT  = 1;

  // FIFO: sixteen channel words, eight pairs
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [4:0] LIMIT_RST = 5'h00;

  typedef enum logic [1:0] {
    fmt_std           = 2'b00,
    fmt_left_aligned  = 2'b01,
    fmt_right_aligned = 2'b10
  } i2stx_fmt_e;

  typedef enum logic [1:0] {
    mode_dual      = 2'b00,
    mode_compact16 = 2'b01,
    mode_compact8  = 2'b10,
    mode_mono      = 2'b11
  } i2stx_mode_e;

  // Size codes: 0=32, 1=24, 2=20, 3=16, 4=8 bits
  localparam logic [2:0] SZ_32 = 3'h0;
  localparam logic [2:0] SZ_24 = 3'h1;
  localparam logic [2:0] SZ_20 = 3'h2;
  localparam logic [2:0] SZ_16 = 3'h3;

  // Master bit clock: half period in system cycles
  localparam int CLK_PERIOD_NS  = 5;
  localparam int LINK_PERIOD_NS = 160;
  localparam int HALF_CYC       = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ==== hdl/i2stx_bitclk.sv ====
// Bit clock source for the transmit channel: divider in master mode,
// synchroniser and edge finder in slave mode.
// Assumes the pin level may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none
module i2stx_bitclk (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic master,
  input  wire logic inv,
  input  wire logic sclk_i,
  output logic      sclk_o,
  output logic      fall_p,
  output logic      rise_p
);
  logic [4:0] div_q;
  logic       lvl_q;
  logic       s1_q, s2_q, s3_q;
  logic       cur, prev;

  // Master divider; held still while disabled so the pin idles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_q <= 5'h00;
      lvl_q <= 1'b0;
    end else if (!en || !master) begin
      div_q <= 5'h00;
      lvl_q <= 1'b0;
    end else if (div_q == 5'(i2stx_pkg::HALF_CYC - 1)) begin
      div_q <= 5'h00;
      lvl_q <= ~lvl_q;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // Pin synchroniser; only s2 and s3 feed the edge finder
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= sclk_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Logical clock: inversion undone so falls always mean data change
  always_comb begin
    if (master) begin
      cur  = lvl_q;
      prev = (div_q == 5'h00) ? ~lvl_q : lvl_q;
    end else begin
      cur  = s2_q ^ inv; // [RULE2]
      prev = s3_q ^ inv;
    end
  end

  assign sclk_o = lvl_q ^ inv; // [RULE2]
  assign fall_p = en && prev && !cur;
  assign rise_p = en && !prev && cur;
endmodule
`default_nettype wire

// ==== hdl/i2stx_chan.sv ====
// Serial audio transmit channel: registers, sample FIFO, framing and
// serialiser, plus the joint controls shared with the receive channel.
// Assumes the register master keeps to one-cycle strobes and that the
// receive channel honours rx_en and rx_cfg.
// Functional notes
// (RULE1) Standard, left or right aligned framing
// (RULE2) Bit clock polarity can be inverted
// (RULE3) Dual, compact16, compact8 and mono modes
// (RULE4) Master drives clocks, slave follows them
// (RULE5) Sample size 32, 24, 20, 16, 8
// (RULE6) Wire word size chosen independently
// (RULE7) Empty FIFO sends zero or repeats
// (RULE8) Dual mode: one write per channel, left first
// (RULE9) Compact16: left low half, right high
// (RULE10) Compact8: left 7:0, right 15:8
// (RULE11) Mono: one write per sample
// (RULE12) Host never pushes into a full FIFO
// (RULE13) Level readable, pair counts as two
// (RULE14) Unpaired left makes the level odd
// (RULE15) Request while level below limit
// (RULE16) Even limit, zero disables request
// (RULE17) Disabled channel drives no pins
// (RULE18) Software disables before reconfiguring
// (RULE19) Joint config writes both channels alike
// (RULE20) Joint enable starts both together
// (RULE21) Joint disable stops both together
// (RULE22) Disabled receiver captures nothing
// (RULE23) MSB first, standard delay one bit
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module i2stx_chan (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  input  wire logic        lrclk_i,
  output logic             lrclk_o,
  output logic             lrclk_oe,
  output logic             sd_o,
  output logic             sd_oe,
  output logic             tx_req,
  output logic             rx_en,
  output logic      [12:0] rx_cfg
);
  logic [12:0] cfg_q, rxcfg_q;
  logic        tx_en_q, rx_en_q;
  logic [4:0]  limit_q, count_q;
  logic [31:0] mem_q [i2stx_pkg::FIFO_DEPTH];
  logic [3:0]  wp_q, rp_q;
  logic [31:0] rd_q, e0, e1, word_q, word_sel;
  logic [31:0] last_q [2];
  logic [1:0]  n_push;
  logic        pop, fall_p, sclk_gen, new_slot, lr_next, bit_n;
  logic        lr_q, lr_cur_q, lr1_q, lr2_q, sd_q;
  logic [5:0]  mcnt_q, pos_q, pos_n, ssz, wsz, lead, k;
  logic [1:0]  fmt, mode;
  logic        master, inv, repeat_on;

  // Decode a size code to a bit count
  function automatic logic [5:0] size_bits(input logic [2:0] code);
    if (code == i2stx_pkg::SZ_32) begin
      size_bits = 6'h20;
    end else if (code == i2stx_pkg::SZ_24) begin
      size_bits = 6'h18;
    end else if (code == i2stx_pkg::SZ_20) begin
      size_bits = 6'h14;
    end else if (code == i2stx_pkg::SZ_16) begin
      size_bits = 6'h10;
    end else begin
      size_bits = 6'h08;
    end
  endfunction

  // Configuration fields
  assign fmt       = cfg_q[i2stx_pkg::CFG_FMT_LSB +: 2];
  assign mode      = cfg_q[i2stx_pkg::CFG_MODE_LSB +: 2]; // [RULE3]
  assign inv       = cfg_q[i2stx_pkg::CFG_INV_BIT];
  assign master    = cfg_q[i2stx_pkg::CFG_MASTER_BIT];
  assign repeat_on = cfg_q[i2stx_pkg::CFG_REPEAT_BIT];
  assign ssz       = size_bits(cfg_q[i2stx_pkg::CFG_SSZ_LSB +: 3]); // [RULE5]
  assign wsz       = size_bits(cfg_q[i2stx_pkg::CFG_WSZ_LSB +: 3]); // [RULE6]

  // Configuration and enables; joint paths touch both channels at once.
  // Changing cfg while enabled is allowed but can tear a frame. [RULE18]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q   <= i2stx_pkg::CFG_RST;
      rxcfg_q <= i2stx_pkg::CFG_RST;
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
      limit_q <= i2stx_pkg::LIMIT_RST;
    end else if (wr_en) begin
      if (addr == i2stx_pkg::REG_TX_CFG) begin
        cfg_q <= wr_data[12:0];
      end else if (addr == i2stx_pkg::REG_RX_CFG) begin
        rxcfg_q <= wr_data[12:0];
      end else if (addr == i2stx_pkg::REG_JOINT_CFG) begin
        cfg_q   <= wr_data[12:0]; // [RULE19]
        rxcfg_q <= wr_data[12:0];
      end else if (addr == i2stx_pkg::REG_CTRL) begin
        tx_en_q <= wr_data[i2stx_pkg::CTRL_TX_EN_BIT];
        rx_en_q <= wr_data[i2stx_pkg::CTRL_RX_EN_BIT];
      end else if (addr == i2stx_pkg::REG_JOINT_EN) begin
        if (wr_data[i2stx_pkg::JOINT_OFF_BIT]) begin
          tx_en_q <= 1'b0; // [RULE21]
          rx_en_q <= 1'b0;
        end else if (wr_data[i2stx_pkg::JOINT_ON_BIT]) begin
          tx_en_q <= 1'b1; // [RULE20]
          rx_en_q <= 1'b1;
        end
      end else if (addr == i2stx_pkg::REG_LIMIT) begin
        limit_q <= (wr_data[4:0] > i2stx_pkg::FIFO_FULL) ? i2stx_pkg::FIFO_FULL
                                                          : {wr_data[4:1], 1'b0}; // [RULE16]
      end
    end
  end

  // Receive channel gates its capture with rx_en [RULE22]
  assign rx_en  = rx_en_q;
  assign rx_cfg = rxcfg_q;

  // Split a data write into channel words
  always_comb begin
    e0 = wr_data;
    e1 = wr_data;
    case (mode)
      i2stx_pkg::mode_compact16: begin
        e0 = {16'h0000, wr_data[15:0]}; // [RULE9]
        e1 = {16'h0000, wr_data[31:16]};
      end
      i2stx_pkg::mode_compact8: begin
        e0 = {24'h000000, wr_data[7:0]}; // [RULE10]
        e1 = {24'h000000, wr_data[15:8]};
      end
      default: begin
        e0 = wr_data; // [RULE8] [RULE11]
        e1 = wr_data;
      end
    endcase
  end

  // Dual mode pushes one word; the others push a pair, mono duplicated.
  // A write without room is dropped whole so pairs never split. [RULE12]
  always_comb begin
    n_push = 2'd0;
    if (wr_en && addr == i2stx_pkg::REG_DATA) begin
      if (mode == i2stx_pkg::mode_dual) begin
        n_push = (count_q != i2stx_pkg::FIFO_FULL) ? 2'd1 : 2'd0; // [RULE8]
      end else begin
        n_push = (count_q < 5'(i2stx_pkg::FIFO_FULL - 1)) ? 2'd2 : 2'd0; // [RULE11]
      end
    end
  end

  // FIFO storage and pointers; level is the word count [RULE13] [RULE14]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q    <= 4'h0;
      rp_q    <= 4'h0;
      count_q <= 5'h00;
    end else begin
      if (n_push != 2'd0) begin
        mem_q[wp_q] <= e0;
      end
      if (n_push == 2'd2) begin
        mem_q[wp_q + 4'h1] <= e1;
      end
      wp_q    <= wp_q + {2'b00, n_push};
      rp_q    <= rp_q + {3'b000, pop};
      count_q <= count_q + {3'b000, n_push} - {4'h0, pop};
    end
  end

  // Service request while the level is under the limit [RULE15] [RULE16]
  assign tx_req = (count_q < limit_q);

  // Bit clock edges from the divider or the pin
  i2stx_bitclk u_bitclk (
    .clock  (clock),
    .rst    (rst),
    .en     (tx_en_q),
    .master (master),
    .inv    (inv),
    .sclk_i (sclk_i),
    .sclk_o (sclk_gen),
    .fall_p (fall_p),
    .rise_p ()
  );

  // Frame clock pin synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lr1_q <= 1'b0;
      lr2_q <= 1'b0;
    end else begin
      lr1_q <= lrclk_i;
      lr2_q <= lr1_q;
    end
  end

  // Frame timing: own counter in master mode, pin in slave mode [RULE4]
  assign lr_next  = master ? ((mcnt_q == wsz - 6'h01) ? ~lr_q : lr_q) : lr2_q;
  assign new_slot = (lr_next != lr_cur_q);
  assign pos_n    = new_slot ? 6'h00 : pos_q + 6'h01;
  assign pop      = fall_p && new_slot && (count_q != 5'h00);

  // Slot and bit position, updated on data-change edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mcnt_q   <= 6'h00;
      lr_q     <= 1'b1;
      lr_cur_q <= 1'b1;
      pos_q    <= 6'h00;
    end else if (!tx_en_q) begin
      // Primed so the first fall toggles into a full-length left slot
      mcnt_q   <= wsz - 6'h01;
      lr_q     <= 1'b1;
      lr_cur_q <= 1'b1;
      pos_q    <= 6'h00;
    end else if (fall_p) begin
      mcnt_q   <= (mcnt_q == wsz - 6'h01) ? 6'h00 : mcnt_q + 6'h01; // [RULE6]
      lr_q     <= lr_next; // Low selects left [RULE23]
      lr_cur_q <= lr_next;
      pos_q    <= pos_n;
    end
  end

  // Word for the slot: FIFO head, else zero or the last one sent [RULE7]
  always_comb begin
    word_sel = word_q;
    if (new_slot) begin
      if (count_q != 5'h00) begin
        word_sel = mem_q[rp_q];
      end else if (repeat_on) begin
        word_sel = last_q[lr_next];
      end else begin
        word_sel = 32'h00000000;
      end
    end
  end

  // First data bit position within the slot [RULE1] [RULE23]
  always_comb begin
    case (fmt)
      i2stx_pkg::fmt_std:           lead = 6'h01;
      i2stx_pkg::fmt_right_aligned: lead = (wsz > ssz) ? wsz - ssz : 6'h00;
      default:                      lead = 6'h00;
    endcase
    k     = pos_n - lead;
    bit_n = 1'b0;
    if (pos_n >= lead && k < ssz && pos_n < wsz) begin
      bit_n = word_sel[5'(ssz - 6'h01 - k)]; // MSB first [RULE5]
    end else if (fmt == i2stx_pkg::fmt_std && new_slot && ssz >= wsz) begin
      bit_n = word_q[5'(ssz - wsz)]; // Last bit spills into next slot [RULE23]
    end
  end

  // Serialiser registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_q    <= 32'h00000000;
      last_q[0] <= 32'h00000000;
      last_q[1] <= 32'h00000000;
      sd_q      <= 1'b0;
    end else if (!tx_en_q) begin
      sd_q <= 1'b0;
      word_q <= 32'h00000000; // No stale spill bit after enable
    end else if (fall_p) begin
      word_q <= word_sel;
      sd_q   <= bit_n;
      if (new_slot) begin
        last_q[lr_next] <= word_sel;
      end
    end
  end

  // Pin drivers; nothing is driven while disabled [RULE17] [RULE4]
  assign sd_o     = sd_q;
  assign sd_oe    = tx_en_q;
  assign sclk_o   = sclk_gen;
  assign sclk_oe  = tx_en_q && master;
  assign lrclk_o  = lr_q;
  assign lrclk_oe = tx_en_q && master;

  // Register reads answer one cycle later; unmapped reads return zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q <= 32'h00000000;
    end else if (rd_en) begin
      if (addr == i2stx_pkg::REG_TX_CFG) begin
        rd_q <= {19'h00000, cfg_q};
      end else if (addr == i2stx_pkg::REG_RX_CFG) begin
        rd_q <= {19'h00000, rxcfg_q};
      end else if (addr == i2stx_pkg::REG_CTRL) begin
        rd_q <= {30'h00000000, rx_en_q, tx_en_q};
      end else if (addr == i2stx_pkg::REG_LEVEL) begin
        rd_q <= {27'h0000000, count_q}; // [RULE13]
      end else if (addr == i2stx_pkg::REG_LIMIT) begin
        rd_q <= {27'h0000000, limit_q};
      end else if (addr == i2stx_pkg::REG_STATUS) begin
        rd_q <= {30'h00000000, count_q == i2stx_pkg::FIFO_FULL, tx_req};
      end else begin
        rd_q <= 32'h00000000;
      end
    end else begin
      rd_q <= 32'h00000000;
    end
  end
  assign rd_data = rd_q;

  // Checks
  sequence s_joint_on;
    wr_en && addr == i2stx_pkg::REG_JOINT_EN && wr_data[1:0] == 2'b01;
  endsequence
  property p_joint_on;
    @(posedge clock) disable iff (rst) s_joint_on |=> tx_en_q && rx_en_q;
  endproperty
  a_joint_on: assert property (p_joint_on) else $error("joint enable failed"); // [RULE20]
  property p_joint_off;
    @(posedge clock) disable iff (rst)
      wr_en && addr == i2stx_pkg::REG_JOINT_EN && wr_data[1] |=> !tx_en_q && !rx_en_q;
  endproperty
  a_joint_off: assert property (p_joint_off) else $error("joint disable failed"); // [RULE21]
  property p_joint_cfg;
    @(posedge clock) disable iff (rst)
      wr_en && addr == i2stx_pkg::REG_JOINT_CFG |=> cfg_q == rxcfg_q;
  endproperty
  a_joint_cfg: assert property (p_joint_cfg) else $error("joint cfg differs"); // [RULE19]
  property p_quiet;
    @(posedge clock) disable iff (rst) !tx_en_q |-> !sd_oe && !sclk_oe && !lrclk_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pins driven while off"); // [RULE17]
  property p_pair_push;
    @(posedge clock) disable iff (rst)
      wr_en && addr == i2stx_pkg::REG_DATA && mode != i2stx_pkg::mode_dual
      && count_q < 5'd15 && !pop |=> count_q == $past(count_q) + 5'd2;
  endproperty
  a_pair_push: assert property (p_pair_push) else $error("pair push miscounted"); // [RULE9]
  property p_odd;
    @(posedge clock) disable iff (rst)
      wr_en && addr == i2stx_pkg::REG_DATA && mode == i2stx_pkg::mode_dual
      && !count_q[0] && count_q < 5'd16 && !pop |=> count_q[0];
  endproperty
  a_odd: assert property (p_odd) else $error("unpaired left not odd"); // [RULE14]
  property p_level_read;
    @(posedge clock) disable iff (rst)
      rd_en && addr == i2stx_pkg::REG_LEVEL |=> rd_data == {27'h0, $past(count_q)};
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong"); // [RULE13]
  property p_req_off;
    @(posedge clock) disable iff (rst) limit_q == 5'd0 |-> !tx_req;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request with zero limit"); // [RULE16]
  property p_req_empty;
    @(posedge clock) disable iff (rst) count_q == 5'd0 && limit_q != 5'd0 |-> tx_req;
  endproperty
  a_req_empty: assert property (p_req_empty) else $error("no request when empty"); // [RULE15]
  property p_empty_zero;
    @(posedge clock) disable iff (rst)
      tx_en_q && fall_p && new_slot && count_q == 5'd0 && !repeat_on |=> word_q == 32'h0;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty slot not zero"); // [RULE7]
endmodule
`default_nettype wire

// ==== tb/i2stx_codec_model.sv ====
// Codec model on the far side of the serial audio link: makes bit and
// frame clocks in slave runs and captures every channel slot it hears.
// Assumes the bench resolves pin levels and pulses clr before each run.
`timescale 1ns/1ps
`default_nettype none
module i2stx_codec_model (
  input  wire logic        sclk,
  input  wire logic        lrclk,
  input  wire logic        sd,
  input  wire logic        sd_oe,
  input  wire logic        inv,
  input  wire logic        dly,
  input  wire logic        run,
  input  wire logic        clr,
  input  wire logic [5:0]  wbits,
  output logic             sclk_drv,
  output logic             lrclk_drv,
  output logic      [31:0] word_l,
  output logic      [31:0] word_r,
  output logic      [7:0]  n_slots
);
  logic        lc;
  logic        lr_d;
  logic        s_prev;
  logic        s;
  logic [31:0] sh;

  // Clock stands still while run is low; idle low matches the master idle
  initial begin
    lc = 1'b0;
    lrclk_drv = 1'b1;
    forever begin
      wait (run === 1'b1);
      if (lc == 1'b0) #80 lc = 1'b1;
      repeat (2) begin
        for (int i = 0; i < int'(wbits); i++) begin
          #80 lc = 1'b0;
          if (i == 0) lrclk_drv = ~lrclk_drv; // Low opens the left slot
          #80 lc = 1'b1;
        end
      end
      if (run !== 1'b1) #80 lc = 1'b0;
    end
  end
  assign sclk_drv = lc ^ inv;

  // Sample on the logical rise; standard framing lags the frame clock by one bit
  always @(sclk or posedge clr) begin
    if (clr) begin
      s_prev = 1'b1;
      lr_d = 1'b1;
      sh = 32'h0;
      n_slots = 8'h0;
    end else if (sd_oe === 1'b1) begin
      // Every logical rise counts; the logical clock idles low, so the first is real
      if ((sclk ^ inv) === 1'b1) begin
        s = dly ? lr_d : lrclk;
        if (s != s_prev) begin
          if (s_prev) word_r = sh;
          else word_l = sh;
          n_slots = n_slots + 8'h1;
          sh = {31'h0, sd};
        end else begin
          sh = {sh[30:0], sd}; // MSB arrives first
        end
        s_prev = s;
        lr_d = lrclk;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/i2stx_chan_bench.sv ====
// Self-checking bench for the transmit channel: register port tasks,
// FIFO level and request checks, joint controls and framed transfers.
// Assumes the codec model captures slots; pins are resolved here.
`timescale 1ns/1ps
`default_nettype none
module i2stx_chan_bench;
  localparam logic [1:0] F_STD = i2stx_pkg::fmt_std;
  localparam logic [1:0] F_LA  = i2stx_pkg::fmt_left_aligned;
  localparam logic [1:0] F_RA  = i2stx_pkg::fmt_right_aligned;
  localparam logic [1:0] M_DU  = i2stx_pkg::mode_dual;
  localparam logic [1:0] M_C16 = i2stx_pkg::mode_compact16;
  localparam logic [1:0] M_C8  = i2stx_pkg::mode_compact8;
  localparam logic [1:0] M_MO  = i2stx_pkg::mode_mono;
  logic        clock, rst, wr_en, rd_en, sclk_o, sclk_oe, lrclk_o, lrclk_oe;
  logic        sd_o, sd_oe, tx_req, rx_en, sclk_drv, lrclk_drv, inv, dly, run, clr;
  logic [7:0]  addr, n_slots;
  logic [31:0] wr_data, rd_data, word_l, word_r;
  logic [12:0] rx_cfg;
  logic [5:0]  wbits;
  wire         sclk_pin  = sclk_oe ? sclk_o : sclk_drv;
  wire         lrclk_pin = lrclk_oe ? lrclk_o : lrclk_drv;
  int          n_mismatch, n_tests, cyc;

  i2stx_chan u_i2stx_chan (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sclk_i(sclk_pin), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .lrclk_i(lrclk_pin), .lrclk_o(lrclk_o), .lrclk_oe(lrclk_oe),
    .sd_o(sd_o), .sd_oe(sd_oe), .tx_req(tx_req), .rx_en(rx_en), .rx_cfg(rx_cfg));
  i2stx_codec_model u_i2stx_codec_model (.sclk(sclk_pin), .lrclk(lrclk_pin), .sd(sd_o),
    .sd_oe(sd_oe), .inv(inv), .dly(dly), .run(run), .clr(clr), .wbits(wbits),
    .sclk_drv(sclk_drv), .lrclk_drv(lrclk_drv), .word_l(word_l), .word_r(word_r),
    .n_slots(n_slots));

  // System clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobes launched just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  function automatic logic [12:0] mk(input logic [1:0] f, input logic v,
    input logic [1:0] m, input logic ms, input logic [2:0] ss, input logic [2:0] ws,
    input logic rp);
    mk = {rp, ws, ss, ms, m, v, f};
  endfunction

  function automatic logic [5:0] wb(input logic [2:0] k);
    case (k)
      3'h0: wb = 6'h20;
      3'h1: wb = 6'h18;
      3'h2: wb = 6'h14;
      3'h3: wb = 6'h10;
      default: wb = 6'h08;
    endcase
  endfunction

  task automatic t_reset();
    chk({sclk_oe, lrclk_oe, sd_oe, tx_req, rx_en}, 0);
    rchk(i2stx_pkg::REG_LEVEL, 0);
    rchk(i2stx_pkg::REG_LIMIT, 0);
    rchk(8'h30, 0);
  endtask

  task automatic t_fifo();
    logic [31:0] v;
    v = 32'h1;
    wr(i2stx_pkg::REG_TX_CFG, 32'(mk(F_STD, 0, M_DU, 1, 4, 4, 0)));
    wr(i2stx_pkg::REG_DATA, 32'h11);
    rchk(i2stx_pkg::REG_LEVEL, 1);
    wr(i2stx_pkg::REG_DATA, 32'h22);
    rchk(i2stx_pkg::REG_LEVEL, 2);
    repeat (14) wr(i2stx_pkg::REG_DATA, 32'h33);
    rchk(i2stx_pkg::REG_LEVEL, 16);
    rchk(i2stx_pkg::REG_STATUS, 32'h2);
    wr(i2stx_pkg::REG_LIMIT, 16);
    @(negedge clock);
    chk(tx_req, 0);
    wr(i2stx_pkg::REG_LIMIT, 5);
    rchk(i2stx_pkg::REG_LIMIT, 4);
    wr(i2stx_pkg::REG_CTRL, 1);
    // Drain by transmitting; the level is polled, not waited on blindly
    for (int i = 0; i < 80 && v !== 32'h0; i++) begin
      repeat (100) @(posedge clock);
      rd(i2stx_pkg::REG_LEVEL, v);
    end
    chk(v, 0);
    chk(tx_req, 1);
    rchk(i2stx_pkg::REG_STATUS, 32'h1);
    wr(i2stx_pkg::REG_LIMIT, 0);
    @(negedge clock);
    chk(tx_req, 0);
    wr(i2stx_pkg::REG_CTRL, 0);
  endtask

  task automatic t_joint();
    logic [12:0] c;
    c = mk(F_RA, 1, M_MO, 0, 3, 3, 1);
    wr(i2stx_pkg::REG_JOINT_CFG, 32'(c));
    @(negedge clock);
    chk(rx_cfg, c);
    rchk(i2stx_pkg::REG_TX_CFG, c);
    wr(i2stx_pkg::REG_JOINT_EN, 1);
    @(negedge clock);
    chk({rx_en, sd_oe}, 2'b11);
    rchk(i2stx_pkg::REG_CTRL, 3);
    wr(i2stx_pkg::REG_JOINT_EN, 3);
    @(negedge clock);
    chk({rx_en, sd_oe}, 2'b00);
  endtask

  task automatic slots(input int n);
    for (int i = 0; i < 20000 && n_slots < 8'(n); i++) @(posedge clock);
  endtask

  // One pair through the link: first frame carries it, second is the empty case
  task automatic tx(input logic [12:0] c, input logic [31:0] d0, d1, l1, r1, l2, r2);
    wr(i2stx_pkg::REG_CTRL, 0);
    wr(i2stx_pkg::REG_TX_CFG, 32'(c));
    wr(i2stx_pkg::REG_DATA, d0);
    if (c[4:3] == M_DU) wr(i2stx_pkg::REG_DATA, d1);
    rchk(i2stx_pkg::REG_LEVEL, 2);
    inv <= c[2];
    dly <= (c[1:0] == F_STD);
    wbits <= wb(c[11:9]);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    wr(i2stx_pkg::REG_CTRL, 1);
    run <= ~c[5];
    slots(3);
    chk(word_l, l1);
    chk(word_r, r1);
    slots(5);
    chk(word_l, l2);
    chk(word_r, r2);
    run <= 1'b0;
    wr(i2stx_pkg::REG_CTRL, 0);
    @(negedge clock);
    chk({sclk_oe, lrclk_oe, sd_oe}, 0);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {wr_en, rd_en, inv, dly, run, clr} = 6'h0;
    addr = 8'h0;
    wr_data = 32'h0;
    wbits = 6'h10;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_fifo();
    t_joint();
    tx(mk(F_STD, 0, M_C16, 1, 3, 3, 0), 32'hbeef1234, 0, 16'h1234, 16'hbeef, 0, 0);
    tx(mk(F_LA, 0, M_C16, 1, 3, 0, 0), 32'hbeef1234, 0, 32'h12340000, 32'hbeef0000, 0, 0);
    tx(mk(F_RA, 0, M_C16, 1, 3, 0, 0), 32'hbeef1234, 0, 16'h1234, 16'hbeef, 0, 0);
    tx(mk(F_STD, 0, M_C8, 1, 4, 4, 0), 32'hffffa55a, 0, 8'h5a, 8'ha5, 0, 0);
    tx(mk(F_STD, 1, M_C16, 1, 3, 3, 1), 32'hbeef1234, 0, 16'h1234, 16'hbeef, 16'h1234,
       16'hbeef);
    tx(mk(F_STD, 0, M_MO, 1, 3, 3, 0), 32'h1357, 0, 16'h1357, 16'h1357, 0, 0);
    tx(mk(F_STD, 0, M_DU, 1, 0, 0, 1), 32'h8badf00d, 32'h13579bdf, 32'h8badf00d,
       32'h13579bdf, 32'h8badf00d, 32'h13579bdf);
    tx(mk(F_LA, 0, M_DU, 1, 1, 0, 0), 32'habcdef, 32'h123456, 32'habcdef00, 32'h12345600,
       0, 0);
    tx(mk(F_STD, 0, M_C16, 0, 3, 3, 0), 32'hbeef1234, 0, 16'h1234, 16'hbeef, 0, 0);
    tx(mk(F_RA, 0, M_DU, 1, 2, 1, 0), 32'hfffabcde, 32'h12345, 32'habcde, 32'h12345,
       0, 0);
    stop_test();
  end
endmodule
`default_nettype wire
